// ===== common/cfgr_defines.svh
`ifndef CFGR_DEFINES_SVH
`define CFGR_DEFINES_SVH

`define CFGR_OFS_OVF_PLL 7'h0b
`define CFGR_OFS_FILT 7'h0c
`define CFGR_OFS_RSVD 7'h0d
`define CFGR_OFS_DRV 7'h0e
`define CFGR_OFS_LGAIN 7'h0f

`define CFGR_RST_PLL_DIV 4'h1
`define CFGR_RST_FILT 8'h00
`define CFGR_RST_RSVD 8'h00
`define CFGR_RST_DRV_MODE 1'h0
`define CFGR_RST_DRV_FDIFF 1'h0
`define CFGR_RST_DRV_PDIFF 1'h0
`define CFGR_RST_MUTE 1'h1
`define CFGR_RST_GAIN 7'h00

`define CFGR_GAIN_MAX 7'h77

`define CFGR_BIT_OVF_ADC_L 7
`define CFGR_BIT_OVF_ADC_R 6
`define CFGR_BIT_OVF_DAC_L 5
`define CFGR_BIT_OVF_DAC_R 4
`define CFGR_BIT_DRV_MODE 7
`define CFGR_BIT_DRV_FDIFF 6
`define CFGR_BIT_DRV_HSET 4
`define CFGR_BIT_DRV_PDIFF 3
`define CFGR_BIT_MUTE 7

`endif

// ===== common/cfgr_pkg.sv
package cfgr_pkg;

    typedef struct packed {
        logic [1:0] hpf_left;
        logic [1:0] hpf_right;
        logic fx_left;
        logic deemph_left;
        logic fx_right;
        logic deemph_right;
    } cfgr_filt_t;

    typedef struct packed {
        logic [3:0] ovf;
        logic [3:0] pll_div;
        cfgr_filt_t filt;
        logic [7:0] rsvd;
        logic drv_mode;
        logic drv_fdiff;
        logic drv_pdiff;
        logic mute;
        logic [6:0] gain;
        logic [7:0] rdata;
    } cfgr_state_t;

    typedef struct packed {
        logic [1:0] hpf_left;
        logic [1:0] hpf_right;
        logic fx_left;
        logic deemph_left;
        logic fx_right;
        logic deemph_right;
        logic [4:0] pll_div_value;
        logic drv_acc;
        logic drv_fdiff;
        logic drv_pdiff;
        logic amp_mute;
        logic [6:0] amp_gain;
    } cfgr_ctrl_t;

endpackage

// ===== rtl/cfgr_regs.sv
`timescale 1ns/1ps
`include "cfgr_defines.svh"
module cfgr_regs (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [3:0] i_ovf_event,
    input wire logic i_headset,
    output logic [7:0] o_rdata,
    output cfgr_pkg::cfgr_ctrl_t o_ctrl
);

    cfgr_pkg::cfgr_state_t st_reg;
    cfgr_pkg::cfgr_state_t st_next;
    cfgr_pkg::cfgr_ctrl_t ctrl_reg;
    cfgr_pkg::cfgr_ctrl_t ctrl_next;

    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (i_addr)
            `CFGR_OFS_OVF_PLL: rd_mux = {st_reg.ovf, st_reg.pll_div};
            `CFGR_OFS_FILT: rd_mux = st_reg.filt;
            `CFGR_OFS_RSVD: rd_mux = st_reg.rsvd;
            `CFGR_OFS_DRV: begin
                rd_mux[`CFGR_BIT_DRV_MODE] = st_reg.drv_mode;
                rd_mux[`CFGR_BIT_DRV_FDIFF] = st_reg.drv_fdiff;
                rd_mux[`CFGR_BIT_DRV_HSET] = i_headset;
                rd_mux[`CFGR_BIT_DRV_PDIFF] = st_reg.drv_pdiff;
            end
            `CFGR_OFS_LGAIN: rd_mux = {st_reg.mute, st_reg.gain};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.rdata = i_rd ? rd_mux : st_reg.rdata;
        // read clears first, new events are ORed after so the set wins
        if (i_rd && i_addr == `CFGR_OFS_OVF_PLL) begin
            st_next.ovf = 4'h0;
        end
        st_next.ovf = st_next.ovf | i_ovf_event;
        if (i_wr) begin
            case (i_addr)
                `CFGR_OFS_OVF_PLL: st_next.pll_div = i_wdata[3:0];
                `CFGR_OFS_FILT: st_next.filt = i_wdata;
                // kept as written; host keeps it zero
                `CFGR_OFS_RSVD: st_next.rsvd = i_wdata;
                `CFGR_OFS_DRV: begin
                    st_next.drv_mode = i_wdata[`CFGR_BIT_DRV_MODE];
                    // both set is the host's fault, stored as written
                    st_next.drv_fdiff = i_wdata[`CFGR_BIT_DRV_FDIFF];
                    st_next.drv_pdiff = i_wdata[`CFGR_BIT_DRV_PDIFF];
                end
                `CFGR_OFS_LGAIN: begin
                    st_next.mute = i_wdata[`CFGR_BIT_MUTE];
                    st_next.gain = i_wdata[6:0];
                end
                default: st_next.pll_div = st_reg.pll_div;
            endcase
        end
    end

    always_comb begin
        ctrl_next.hpf_left = st_next.filt.hpf_left;
        ctrl_next.hpf_right = st_next.filt.hpf_right;
        ctrl_next.fx_left = st_next.filt.fx_left;
        ctrl_next.deemph_left = st_next.filt.deemph_left;
        ctrl_next.fx_right = st_next.filt.fx_right;
        ctrl_next.deemph_right = st_next.filt.deemph_right;
        ctrl_next.pll_div_value = (st_next.pll_div == 4'h0) ?
            5'h10 : {1'b0, st_next.pll_div};
        ctrl_next.drv_acc = st_next.drv_mode;
        ctrl_next.drv_fdiff = st_next.drv_fdiff;
        ctrl_next.drv_pdiff = st_next.drv_pdiff;
        ctrl_next.amp_mute = st_next.mute;
        ctrl_next.amp_gain = (st_next.gain > `CFGR_GAIN_MAX) ?
            `CFGR_GAIN_MAX : st_next.gain;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg.ovf <= 4'h0;
            st_reg.pll_div <= `CFGR_RST_PLL_DIV;
            st_reg.filt <= `CFGR_RST_FILT;
            st_reg.rsvd <= `CFGR_RST_RSVD;
            st_reg.drv_mode <= `CFGR_RST_DRV_MODE;
            st_reg.drv_fdiff <= `CFGR_RST_DRV_FDIFF;
            st_reg.drv_pdiff <= `CFGR_RST_DRV_PDIFF;
            st_reg.mute <= `CFGR_RST_MUTE;
            st_reg.gain <= `CFGR_RST_GAIN;
            st_reg.rdata <= 8'h00;
            ctrl_reg <= '0;
            ctrl_reg.pll_div_value <= {1'b0, `CFGR_RST_PLL_DIV};
            ctrl_reg.amp_mute <= `CFGR_RST_MUTE;
        end else begin
            st_reg <= st_next;
            ctrl_reg <= ctrl_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_ctrl = ctrl_reg;

    property p_sticky;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ovf_event[3] |=> st_reg.ovf[3];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag not set");

    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_reg.ovf[2] && !(i_rd && i_addr == `CFGR_OFS_OVF_PLL))
            |=> st_reg.ovf[2];
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");

    property p_clear;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_rd && i_addr == `CFGR_OFS_OVF_PLL && i_ovf_event == 4'h0)
            |=> (st_reg.ovf == 4'h0) && (o_rdata[7:4] == $past(st_reg.ovf));
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_div;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_OVF_PLL && i_wdata[3:0] == 4'h0)
            |=> o_ctrl.pll_div_value == 5'h10;
    endproperty
    a_div: assert property (p_div) else $error("divide 16 wrong");

    property p_filt;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_FILT) |=> ({o_ctrl.hpf_left,
            o_ctrl.hpf_right, o_ctrl.fx_left, o_ctrl.deemph_left,
            o_ctrl.fx_right, o_ctrl.deemph_right} == $past(i_wdata));
    endproperty
    a_filt: assert property (p_filt) else $error("filter ctl wrong");

    property p_acc;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_DRV)
            |=> o_ctrl.drv_acc == $past(i_wdata[7]);
    endproperty
    a_acc: assert property (p_acc) else $error("drive mode wrong");

    property p_hset;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_rd && i_addr == `CFGR_OFS_DRV) |=> o_rdata[4] == $past(i_headset);
    endproperty
    a_hset: assert property (p_hset) else $error("headset bit wrong");

    property p_sat;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        o_ctrl.amp_gain <= `CFGR_GAIN_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("gain not saturated");

    property p_mute;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_LGAIN)
            |=> o_ctrl.amp_mute == $past(i_wdata[7]);
    endproperty
    a_mute: assert property (p_mute) else $error("mute wrong");

    property p_div_val;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_OVF_PLL && i_wdata[3:0] != 4'h0)
            |=> o_ctrl.pll_div_value == {1'b0, $past(i_wdata[3:0])};
    endproperty
    a_div_val: assert property (p_div_val) else $error("div wrong");

    // the clearing read must not swallow an event of the same cycle
    property p_set_wins;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_rd && i_addr == `CFGR_OFS_OVF_PLL && i_ovf_event != 4'h0)
            |=> st_reg.ovf == $past(i_ovf_event);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost");

    property p_gain;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_LGAIN && i_wdata[6:0] <= `CFGR_GAIN_MAX)
            |=> o_ctrl.amp_gain == $past(i_wdata[6:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain wrong");

    property p_sat_hi;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_LGAIN && i_wdata[6:0] > `CFGR_GAIN_MAX)
            |=> o_ctrl.amp_gain == `CFGR_GAIN_MAX;
    endproperty
    a_sat_hi: assert property (p_sat_hi) else $error("no clamp");

    property p_drv_cfg;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && i_addr == `CFGR_OFS_DRV) |=>
            (o_ctrl.drv_fdiff == $past(i_wdata[`CFGR_BIT_DRV_FDIFF])) &&
            (o_ctrl.drv_pdiff == $past(i_wdata[`CFGR_BIT_DRV_PDIFF]));
    endproperty
    a_drv_cfg: assert property (p_drv_cfg) else $error("cfg wrong");

    // unused driver bits must read zero whatever the host wrote
    property p_drv_rsvd;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_rd && i_addr == `CFGR_OFS_DRV)
            |=> (o_rdata[5] == 1'b0) && (o_rdata[2:0] == 3'h0);
    endproperty
    a_drv_rsvd: assert property (p_drv_rsvd) else $error("stray bit");

    c_clear: cover property (@(posedge i_ref_clk)
        i_rd && i_addr == `CFGR_OFS_OVF_PLL && st_reg.ovf != 4'h0);
    c_race: cover property (@(posedge i_ref_clk)
        i_rd && i_addr == `CFGR_OFS_OVF_PLL && i_ovf_event != 4'h0);
    c_sat: cover property (@(posedge i_ref_clk)
        i_wr && i_addr == `CFGR_OFS_LGAIN && i_wdata[6:0] > 7'h77);
    c_div16: cover property (@(posedge i_ref_clk)
        i_wr && i_addr == `CFGR_OFS_OVF_PLL && i_wdata[3:0] == 4'h0);
    c_hset: cover property (@(posedge i_ref_clk)
        i_rd && i_addr == `CFGR_OFS_DRV && i_headset);

endmodule

// ===== tb/cfgr_host.sv
`timescale 1ns/1ps
module cfgr_host (
    input wire logic i_clk,
    output logic o_wr,
    output logic o_rd,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 7'h00;
        o_wdata = 8'h00;
    end
    // the host sanitises its own writes, the block relies on it
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 7'h0d) v = 8'h00;
        if (a == 7'h0e) v = v & 8'hc8;
        if (a == 7'h0e && v[6]) v[3] = 1'b0;
        @(negedge i_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = v;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~v;
    endtask
    task automatic rd(input logic [6:0] a);
        @(negedge i_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
    endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rstn, hs, wr, rd, rd_d = 1'b0;
    logic [3:0] ev;
    logic [6:0] a, g;
    logic [7:0] d, o_rdata, v, w;
    logic [15:0] e;
    logic [15:0] exp_q[$];
    logic [6:0] gt[4] = '{7'h00, 7'h77, 7'h78, 7'h7f};
    cfgr_pkg::cfgr_ctrl_t c;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, seed, i;
    always #12.5 clk = ~clk;
    cfgr_host u_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(a),
        .o_wdata(d));
    cfgr_regs u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_wr(wr), .i_rd(rd),
        .i_addr(a), .i_wdata(d), .i_ovf_event(ev), .i_headset(hs),
        .o_rdata(o_rdata), .o_ctrl(c));
    task automatic chk(input string n, input logic [7:0] x, y);
        samples_checked++;
        if (y !== x) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, x, y);
        end
    endtask
    task automatic rdx(input logic [6:0] ad, input logic [7:0] x,
        input logic [7:0] m = 8'hff);
        exp_q.push_back({m, x});
        u_host.rd(ad);
    endtask
    task automatic pulse(input logic [3:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 4'h0;
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // read data is registered on the rising edge that samples rd and checked at the next falling edge
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            chk("rdata", e[7:0] & e[15:8], o_rdata & e[15:8]);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        seed = 35;
        rstn = 1'b0;
        ev = 4'h0;
        hs = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        chk("pll", 8'd1, 8'(c.pll_div_value));
        chk("mute", 8'd1, 8'(c.amp_mute));
        rdx(7'h0b, 8'h01);
        rdx(7'h0c, 8'h00);
        rdx(7'h0e, 8'h00);
        rdx(7'h0f, 8'h80);
        $display("reset test done");
        pulse(4'ha);
        repeat (3) @(negedge clk);
        rdx(7'h0b, 8'ha1);
        rdx(7'h0b, 8'h01);
        fork
            pulse(4'h5);
            rdx(7'h0b, 8'h01);
        join
        rdx(7'h0b, 8'h51);
        rdx(7'h0b, 8'h01);
        $display("overflow test done");
        for (i = 0; i < 16; i++) begin
            g = 7'($random(seed));
            u_host.wr(7'h0b, {g[3:0], i[3:0]});
            chk("pll", (i == 0) ? 8'd16 : 8'(i), 8'(c.pll_div_value));
            rdx(7'h0b, {4'h0, i[3:0]});
        end
        for (i = 0; i < 4; i++) begin
            g = 7'($random(seed));
            v = {i[1:0], ~i[1:0], g[3:0]};
            u_host.wr(7'h0c, v);
            w = {c.hpf_left, c.hpf_right, c.fx_left, c.deemph_left,
                c.fx_right, c.deemph_right};
            chk("filt", v, w);
            rdx(7'h0c, v);
        end
        u_host.wr(7'h0d, 8'hff);
        rdx(7'h0d, 8'h00);
        u_host.wr(7'h10, 8'h5a);
        rdx(7'h10, 8'h00);
        $display("filter test done");
        for (i = 0; i < 4; i++) begin
            hs = i[0];
            u_host.wr(7'h0e, 8'hff);
            v = i[1] ? 8'h40 : {i[0], 7'h08};
            u_host.wr(7'h0e, v);
            w = {5'h0, c.drv_acc, c.drv_fdiff, c.drv_pdiff};
            chk("drv", i[1] ? 8'h02 : {5'h0, i[0], 2'b01}, w);
            rdx(7'h0e, v | {3'h0, hs, 4'h0});
        end
        $display("driver test done");
        for (i = 0; i < 7; i++) begin
            g = (i < 4) ? gt[i] : 7'($random(seed));
            u_host.wr(7'h0f, {i[0], g});
            chk("gain", g > 7'h77 ? 8'h77 : 8'(g), 8'(c.amp_gain));
            chk("mute", 8'(i[0]), 8'(c.amp_mute));
            rdx(7'h0f, {i[0], g});
        end
        repeat (3) @(negedge clk);
        $display("gain test done");
        conclude();
    end
endmodule
